// ---- src/adc_acquire_convert_sequencer.sv ----
// Purpose: go/done sequencer for a 12-bit successive-approximation converter
// Assumes: go_set and ctl2 writes come from logic on mclk
// Notes:   no status marks the acquire/convert boundary; go spans both
//          go cannot be withdrawn once taken; a go while busy is dropped
//          a write during a conversion is stored but only used at the next go
//          front end levels leave on flops fed from the next state
//          the rc source is modelled as a divider of mclk
`timescale 1ns/10ps
`default_nettype none
module adc_acquire_convert_sequencer
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_b,
   // converter_control_two access
   input  wire logic              ctl2_wr_en,
   input  wire logic [CTL2_W-1:0] ctl2_wr_data,
   output logic [CTL2_W-1:0]      converter_control_two,
   // go and done
   input  wire logic              go_set,
   output logic                   go_busy,
   input  wire logic              done_flag_clr,
   output logic                   conversion_done_irq_flag,
   // analog front end
   output logic                   sample_en,
   output logic                   conv_active,
   output logic                   bit_strobe,
   output logic [TAD_IDX_W-1:0]   bit_index
);

   // sequencer state and settings latched at go
   seq_state_t           state_q, state_d;
   logic [CTL2_W-1:0]    ctl2_q, ctl2_d;
   logic [2:0]           clk_sel_q, clk_sel_d;
   logic [TAD_IDX_W-1:0] cnt_q, cnt_d;
   logic [TAD_IDX_W-1:0] acq_tads_q, acq_tads_d;
   logic                 go_q, go_d;
   // completion flag and the one-cycle event that sets it
   logic                 done_q, done_d;
   logic                 conv_end;
   // bit period enable and the live acquisition field
   logic                 tick;
   logic [2:0]           acq_sel;
   // front end levels and index, kept on flops
   logic                 sample_q, sample_d;
   logic                 conv_q, conv_d;
   logic [TAD_IDX_W-1:0] index_q, index_d;

   // converting decode, shared by the strobe gate and the output flops
   function automatic logic in_conv(input seq_state_t s);
      return (s == ST_CONV);
   endfunction

   // automatic acquisition length in bit periods; zero leaves the timing
   // to software, which must then wait before raising go
   function automatic logic [TAD_IDX_W-1:0] acq_span(input logic [2:0] code);
      return TAD_IDX_W'(code) * TAD_IDX_W'(ACQ_TADS_PER_STEP);
   endfunction

   assign acq_sel = ctl2_q[ACQ_SEL_MSB:ACQ_SEL_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // bit period enable; runs only while a request is in flight
   // restarting at idle makes every go begin on a whole bit period
   tad_tick_gen u_tick (
      .mclk  (mclk),
      .rst_b (rst_b),
      .run   (state_q != ST_IDLE),
      .sel   (clk_sel_q),
      .tick  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control register: fields taken live, latched at go
   // bits 7:6 are not built and read back as zero
   always_comb begin
      ctl2_d = ctl2_q;
      if (ctl2_wr_en) begin
         ctl2_d = ctl2_wr_data & CTL2_IMPL_MASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctl2_q <= CTL2_RESET;                        // manual acquire
      end else begin
         ctl2_q <= ctl2_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer; settings latched at go so a mid-flight write cannot
   // stretch or cut the conversion
   always_comb begin
      state_d    = state_q;
      clk_sel_d  = clk_sel_q;
      cnt_d      = cnt_q;
      acq_tads_d = acq_tads_q;
      go_d       = go_q;
      conv_end   = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            // only idle takes a go; a pulse while busy falls through unseen
            if (go_set) begin
               go_d       = 1'b1;
               cnt_d      = '0;
               clk_sel_d  = ctl2_q[CLK_SEL_MSB:CLK_SEL_LSB];
               acq_tads_d = acq_span(acq_sel);
               if (acq_sel == ACQ_MANUAL) begin
                  state_d = ST_CONV;
               end else begin
                  state_d = ST_ACQ;
               end
            end
         end
         ST_ACQ: begin
            // the tick closing the last whole period hands over to conversion
            if (tick) begin
               if (cnt_q == acq_tads_q - 5'h01) begin
                  cnt_d   = '0;
                  state_d = ST_CONV;
               end else begin
                  cnt_d = cnt_q + 5'h01;
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               if (cnt_q == TAD_IDX_W'(CONV_TADS - 1)) begin
                  cnt_d   = '0;
                  go_d     = 1'b0;
                  conv_end = 1'b1;                    // raises the done flag
                  state_d  = ST_IDLE;
               end else begin
                  cnt_d = cnt_q + 5'h01;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;                        // illegal code recovers
            go_d    = 1'b0;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= ST_IDLE;
         clk_sel_q  <= 3'h0;
         cnt_q      <= '0;
         acq_tads_q <= '0;
         go_q       <= 1'b0;
      end else begin
         state_q    <= state_d;
         clk_sel_q  <= clk_sel_d;
         cnt_q      <= cnt_d;
         acq_tads_q <= acq_tads_d;
         go_q       <= go_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // done flag; a finishing conversion beats a clear in the same cycle, so a
   // completion that software has not yet seen is never lost
   always_comb begin
      done_d = done_q;
      if (done_flag_clr) begin
         done_d = 1'b0;
      end
      if (conv_end) begin
         done_d = 1'b1;                               // set beats clear
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // front end controls come from the next state, so these flops change on
   // the same edge as the state register; a decoded level could glitch
   // while the state bits move, and the analog side would see it
   always_comb begin
      sample_d = !in_conv(state_d);                   // resume sampling
      conv_d   = in_conv(state_d);
      index_d  = '0;
      if (in_conv(state_d)) begin
         index_d = cnt_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sample_q <= 1'b1;                            // idle front end samples
         conv_q   <= 1'b0;
         index_q  <= '0;
      end else begin
         sample_q <= sample_d;
         conv_q   <= conv_d;
         index_q  <= index_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; go stays high across acquire and convert alike
   assign converter_control_two    = ctl2_q;
   assign go_busy                  = go_q;
   assign conversion_done_irq_flag = done_q;
   assign sample_en                = sample_q;
   assign conv_active              = conv_q;
   // strobe stays combinational: a flop would put it one cycle behind the
   // bit index that it marks
   assign bit_strobe               = tick && in_conv(state_q);
   assign bit_index                = index_q;

endmodule // adc_acquire_convert_sequencer
`default_nettype wire

// ---- src/adc_seq_pkg.sv ----
// Purpose: shared constants for the converter acquire/convert sequencer
// Assumes: mclk at 100 MHz; internal RC source modelled as a divider of mclk
// Notes:   field positions and reset values of converter_control_two live here
//
// Functional notes
// - with no programmed acquisition delay, setting go stops sampling and starts conversion at once.
// - acquisition_time_select is bits 5:3 of converter_control_two, resets to 000, and 000 means manual.
// - with a nonzero acquisition_time_select, go keeps sampling for that time then converts on its own.
// - at the end of conversion go clears, the done flag sets, and sampling resumes.
// - nothing shows where acquisition ends and conversion begins; go stays set through both.
// - each conversion takes exactly 14 conversion bit periods from start to done.
// - the bit period is 2, 4, 8, 16, 32 or 64 oscillator periods, or the internal RC source.
// - conversion_clock_select codes 000,100,001,101,010,110 give 2..64 periods and x11 the RC source.
package adc_seq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned RC_TAD_NS       = 4000;    // typical rc bit period
   localparam int unsigned RC_TAD_CYCLES   = RC_TAD_NS / CLK_PERIOD_NS;
   localparam int unsigned TAD_CNT_W       = 9;
   localparam int unsigned CONV_TADS       = 14;      // bit periods per conversion
   localparam int unsigned TAD_IDX_W       = 5;

   ////////////////////////////////////////////////////////////////////////////
   // converter_control_two layout
   localparam int unsigned CTL2_W          = 8;
   localparam int unsigned ACQ_SEL_LSB     = 3;
   localparam int unsigned ACQ_SEL_MSB     = 5;
   localparam int unsigned CLK_SEL_LSB     = 0;
   localparam int unsigned CLK_SEL_MSB     = 2;
   localparam logic [7:0]  CTL2_IMPL_MASK  = 8'h3F;   // bits 7:6 read zero
   localparam logic [7:0]  CTL2_RESET      = 8'h00;
   localparam logic [2:0]  ACQ_MANUAL      = 3'h0;
   localparam int unsigned ACQ_TADS_PER_STEP = 2;     // delay = code * this

   ////////////////////////////////////////////////////////////////////////////
   // conversion clock select codes
   localparam logic [2:0]  CS_DIV2         = 3'h0;
   localparam logic [2:0]  CS_DIV4         = 3'h4;
   localparam logic [2:0]  CS_DIV8         = 3'h1;
   localparam logic [2:0]  CS_DIV16        = 3'h5;
   localparam logic [2:0]  CS_DIV32        = 3'h2;
   localparam logic [2:0]  CS_DIV64        = 3'h6;

   // sequencer states, gray along idle -> acquire -> convert
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACQ  = 2'h1,
      ST_CONV = 2'h3
   } seq_state_t;

   // mclk cycles in one conversion bit period for a select code
   function automatic logic [TAD_CNT_W-1:0] tad_cycles(input logic [2:0] sel);
      logic [TAD_CNT_W-1:0] n;
      n = TAD_CNT_W'(RC_TAD_CYCLES);                  // x11 picks rc
      unique case (sel)
         CS_DIV2:  n = 9'h002;
         CS_DIV4:  n = 9'h004;
         CS_DIV8:  n = 9'h008;
         CS_DIV16: n = 9'h010;
         CS_DIV32: n = 9'h020;
         CS_DIV64: n = 9'h040;
         default:  n = TAD_CNT_W'(RC_TAD_CYCLES);
      endcase
      return n;
   endfunction

endpackage

// ---- src/tad_tick_gen.sv ----
// Purpose: one-cycle enable at the end of each conversion bit period
// Assumes: sel held steady while run is high
// Notes:   count restarts whenever run drops, so bit periods align to go
`timescale 1ns/10ps
`default_nettype none
module tad_tick_gen
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // control
   input  wire logic       run,
   input  wire logic [2:0] sel,
   // enable out
   output logic            tick
);

   logic [TAD_CNT_W-1:0] cnt_q;
   logic [TAD_CNT_W-1:0] cnt_d;
   logic [TAD_CNT_W-1:0] last;

   ////////////////////////////////////////////////////////////////////////////
   // divider, period picked by the select code
   always_comb begin
      last  = tad_cycles(sel) - 9'h001;
      tick  = run && (cnt_q == last);
      cnt_d = cnt_q + 9'h001;
      if (!run || tick) begin
         cnt_d = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule // tad_tick_gen
`default_nettype wire

// ---- verification/adc_front_end_model.sv ----
// Purpose: analog front end stand-in, counts decisions per conversion
// Assumes: strobes only arrive while converting
// Notes:   count restarts at each conversion start
`timescale 1ns/10ps
`default_nettype none
module adc_front_end_model (
   input  wire logic       mclk,
   input  wire logic       conv_active,
   input  wire logic       bit_strobe,
   output logic      [4:0] strobes
);
   logic conv_q;
   // one comparator decision per strobe; count holds once idle
   always_ff @(posedge mclk) begin
      conv_q <= conv_active;
      if (conv_active && !conv_q) strobes <= {4'h0, bit_strobe};
      else if (bit_strobe) strobes <= strobes + 5'h01;
   end
endmodule // adc_front_end_model
`default_nettype wire

// ---- verification/adc_seq_checker.sv ----
// Purpose: port assertions for the converter sequencer
// Assumes: settings are written only while idle
// Notes:   bound to the sequencer after the module
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic                 mclk,
   input wire logic                 rst_b,
   // register, go and done
   input wire logic                 ctl2_wr_en,
   input wire logic [CTL2_W-1:0]    ctl2_wr_data,
   input wire logic [CTL2_W-1:0]    converter_control_two,
   input wire logic                 go_set,
   input wire logic                 go_busy,
   input wire logic                 done_flag_clr,
   input wire logic                 conversion_done_irq_flag,
   // front end
   input wire logic                 sample_en,
   input wire logic                 conv_active,
   input wire logic                 bit_strobe,
   input wire logic [TAD_IDX_W-1:0] bit_index
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   // a go taken from idle, and the last decision of a conversion
   sequence s_go; go_set && !go_busy; endsequence
   sequence s_last; bit_strobe && bit_index == 5'h0D; endsequence
   property p_man; s_go ##0 converter_control_two[5:3] == 3'h0 |=> conv_active; endproperty
   a_man: assert property (p_man) else $error("manual go late");
   property p_acq; s_go ##0 converter_control_two[5:3] != 3'h0 |=> sample_en && go_busy && !conv_active; endproperty
   a_acq: assert property (p_acq) else $error("auto go stopped sampling");
   property p_done; $fell(go_busy) |-> conversion_done_irq_flag && sample_en; endproperty
   a_done: assert property (p_done) else $error("bad completion");
   property p_span; conv_active |-> go_busy && !sample_en; endproperty
   a_span: assert property (p_span) else $error("go dropped in conversion");
   property p_last; s_last |=> !go_busy && !conv_active; endproperty
   a_last: assert property (p_last) else $error("no finish after last bit");
   property p_step; bit_strobe && bit_index < 5'h0D |=> bit_index == $past(bit_index) + 5'h01; endproperty
   a_step: assert property (p_step) else $error("bit index skipped");
   property p_wr; ctl2_wr_en |=> converter_control_two == ($past(ctl2_wr_data) & 8'h3F); endproperty
   a_wr: assert property (p_wr) else $error("register write lost");
   // set wins over clear, so only a lone clear is checked
   property p_clr; done_flag_clr && !bit_strobe |=> !conversion_done_irq_flag; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
endmodule // adc_seq_checker
bind adc_acquire_convert_sequencer adc_seq_checker i_chk (
   .mclk                     (mclk),
   .rst_b                    (rst_b),
   .ctl2_wr_en               (ctl2_wr_en),
   .ctl2_wr_data             (ctl2_wr_data),
   .converter_control_two    (converter_control_two),
   .go_set                   (go_set),
   .go_busy                  (go_busy),
   .done_flag_clr            (done_flag_clr),
   .conversion_done_irq_flag (conversion_done_irq_flag),
   .sample_en                (sample_en),
   .conv_active              (conv_active),
   .bit_strobe               (bit_strobe),
   .bit_index                (bit_index)
);
`default_nettype wire

// ---- verification/test_adc_acquire_convert_sequencer.sv ----
// Purpose: directed bench for the converter sequencer
// Assumes: settings written only while idle
// Notes:   drives and counts on the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_adc_acquire_convert_sequencer;
   import adc_seq_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, ctl2_wr_en = 1'b0, go_set = 1'b0, done_flag_clr = 1'b0;
   logic [7:0] ctl2_wr_data = 8'h00;
   logic [CTL2_W-1:0] converter_control_two;
   logic go_busy, conversion_done_irq_flag, sample_en, conv_active, bit_strobe;
   logic [TAD_IDX_W-1:0] bit_index;
   logic [4:0] strobes;
   int mismatches = 0, tests_run = 0;
   adc_acquire_convert_sequencer i_dut (
      .mclk                     (mclk),
      .rst_b                    (rst_b),
      .ctl2_wr_en               (ctl2_wr_en),
      .ctl2_wr_data             (ctl2_wr_data),
      .converter_control_two    (converter_control_two),
      .go_set                   (go_set),
      .go_busy                  (go_busy),
      .done_flag_clr            (done_flag_clr),
      .conversion_done_irq_flag (conversion_done_irq_flag),
      .sample_en                (sample_en),
      .conv_active              (conv_active),
      .bit_strobe               (bit_strobe),
      .bit_index                (bit_index)
   );
   adc_front_end_model i_fe (
      .mclk        (mclk),
      .conv_active (conv_active),
      .bit_strobe  (bit_strobe),
      .strobes     (strobes)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] d);
      @(negedge mclk) ctl2_wr_en = 1'b1;
      ctl2_wr_data = d;
      @(negedge mclk) ctl2_wr_en = 1'b0;
      check(converter_control_two, d & 8'h3F);
   endtask
   // mclk cycles per bit period, worked out from the select code
   function automatic int bit_cycles(input logic [2:0] sel);
      if (sel[1:0] == 2'h3) return RC_TAD_CYCLES;
      return 2 << (sel[2] + 2 * sel[1:0]);
   endfunction
   // bench floor for the bit period, a plain default tied to no part
   localparam int MIN_TAD_NS = 500;
   // shortest divider code whose bit period still clears the floor
   function automatic logic [2:0] pick_sel();
      logic [2:0] codes [6] = '{CS_DIV2, CS_DIV4, CS_DIV8, CS_DIV16, CS_DIV32, CS_DIV64};
      for (int k = 0; k < 6; k++) begin
         if (bit_cycles(codes[k]) * CLK_PERIOD_NS > MIN_TAD_NS) return codes[k];
      end
      return 3'h3;
   endfunction
   // reset pulled in mid conversion clears go, done, conv_active and the register at once, and sets sample_en
   task automatic reset_mid();
      logic [11:0] lvl;
      wr(8'h03);
      go_set = 1'b1;
      @(negedge mclk) go_set = 1'b0;
      repeat (20) @(negedge mclk);
      check(conv_active, 1'b1);
      rst_b = 1'b0;
      repeat (4) @(negedge mclk);
      lvl = {go_busy, conversion_done_irq_flag, sample_en, conv_active, converter_control_two};
      check(lvl, 12'h200);
      rst_b = 1'b1;
      repeat (2) @(negedge mclk);
      lvl = {go_busy, conversion_done_irq_flag, sample_en, conv_active, converter_control_two};
      check(lvl, 12'h200);
   endtask
   // one go with given clock and delay codes, timed to the cycle
   task automatic run_conv(input logic [2:0] sel, input logic [2:0] acq);
      int n, p, a;
      p = bit_cycles(sel);
      a = 2 * acq * p;
      wr({2'h0, acq, sel});
      repeat (4) @(negedge mclk); // settle the input before go
      go_set = 1'b1;
      @(negedge mclk) go_set = 1'b0;
      n = 1;
      check(sample_en, acq != 3'h0);
      while (!conv_active && n < 9000) begin
         @(negedge mclk);
         n++;
      end
      check(n, 1 + a);
      while (go_busy && n < 9000) begin
         @(negedge mclk);
         n++;
         go_set = (n == 3 + a); // a go while busy must change nothing
      end
      check(n, 1 + a + 14 * p);
      check({conversion_done_irq_flag, sample_en, strobes}, {2'h3, 5'h0E});
      done_flag_clr = 1'b1;
      @(negedge mclk) done_flag_clr = 1'b0;
      check(conversion_done_irq_flag, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 mclk = ~mclk;
   end
   // watchdog well past the longest expected run
   initial begin
      #300000;
      mismatches++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge mclk);
      rst_b = 1'b1;
      check({go_busy, sample_en, converter_control_two}, 10'h100);
      wr(8'hFF);
      for (int i = 0; i < 8; i++) begin
         run_conv(3'(i), 3'h0);
      end
      run_conv(3'h4, 3'h1);
      reset_mid();
      run_conv(3'h0, 3'h7);
      run_conv(pick_sel(), 3'h1);
      conclude();
   end
endmodule // test_adc_acquire_convert_sequencer
`default_nettype wire
